// ==== hw/mcg_pkg.sv ====
/*
  Constants, types and helper functions shared by the microcontroller
  clock output generator and its divider.
  Assumes a single 10 MHz design clock at twice the crystal rate, so one
  crystal period spans two clock cycles.
*/
// What this block does
// [R01] While the crystal runs, the output is always taken from the crystal.
// [R02] The generated clock can be driven out on a general-purpose pin.
// [R03] The crystal path divides by the ratio chosen by a 4-bit code.
// [R04] The RC path passes the RC clock as is, or divides it by 128.
// [R05] Entering standby, a programmed tail of extra cycles runs first.
// [R06] The tail can be 0, 64, 256 or 512 cycles.
// [R07] An interrupt is raised when the standby transition begins.
// [R08] The transition to standby ends within 98304 digital clock periods.
// [R09] Entering sleep moves the source from crystal to RC.
// [R10] Leaving sleep for an active state moves the source back to crystal.
// [R11] Source changes are glitch-free, taken on an RC clock edge; entering shutdown sets SRC_OFF at once.
// [R12] In shutdown no clock is given at all.
// [R13] Tail code 00, 01, 10, 11 maps to 0, 64, 256, 512 cycles.
// [R14] The divider runs only while the enable bit is set.
// [R15] A new divide ratio takes effect only at a period boundary; a change of rc_divide_select switches the RC output at once.
package mcg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'h06;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_TAIL_LSB = 5;
  localparam int CFG_XO_LSB = 1;
  localparam int CFG_RC_BIT = 0;

  typedef struct packed {
    logic enable;
    logic [1:0] tail_code;
    logic [3:0] crystal_divide_code;
    logic rc_divide_select;
  } mcg_cfg_t;

  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_STANDBY, ST_SLEEP, ST_READY, ST_TUNING, ST_RX, ST_TX
  } mcg_state_t;

  typedef enum logic [1:0] {SRC_OFF, SRC_XO, SRC_RC} mcg_src_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DIV_W = 9;
  localparam int TAIL_W = 10;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CRYSTAL_PERIOD_NS = 200;
  localparam int CLK_PER_DIG_PERIOD = CRYSTAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STANDBY_MAX_DIG_PERIODS = 98304;
  localparam int STANDBY_MAX_CYCLES =
    STANDBY_MAX_DIG_PERIODS * CLK_PER_DIG_PERIOD;
  localparam int TIMER_W = 18;
  // 128 RC periods are 256 RC edges
  localparam logic [DIV_W-1:0] RC_SLOW_PERIOD = 9'h100;

  // Output period in clock cycles (half crystal periods)
  function automatic logic [DIV_W-1:0] xo_period(input logic [3:0] code);
    case (code)
      4'h0: xo_period = 9'h002;
      4'h1: xo_period = 9'h003;
      4'h2: xo_period = 9'h004;
      4'h3: xo_period = 9'h006;
      4'h4: xo_period = 9'h008;
      4'h5: xo_period = 9'h00c;
      4'h6: xo_period = 9'h010;
      4'h7: xo_period = 9'h018;
      4'h8: xo_period = 9'h020;
      4'h9: xo_period = 9'h030;
      4'ha: xo_period = 9'h048;
      4'hb: xo_period = 9'h060;
      4'hc: xo_period = 9'h080;
      4'hd: xo_period = 9'h0c0;
      4'he: xo_period = 9'h100;
      default: xo_period = 9'h180;
    endcase
  endfunction : xo_period

  function automatic logic [TAIL_W-1:0] tail_cycles(input logic [1:0] code);
    case (code)
      2'h0: tail_cycles = 10'h000;
      2'h1: tail_cycles = 10'h040;
      2'h2: tail_cycles = 10'h100;
      default: tail_cycles = 10'h200;
    endcase
  endfunction : tail_cycles

endpackage : mcg_pkg

// ==== hw/mcg_sqdiv.sv ====
/*
  Programmable square-wave divider: one output period per "period"
  advance strobes, high for the first half (rounded up).
  Assumes advance is a one-cycle strobe synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module mcg_sqdiv
  import mcg_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic advance,
  input wire logic [W-1:0] period,
  output logic wave
);

  logic [W-1:0] cnt;
  logic [W-1:0] cur_period;
  logic [W-1:0] next_cnt;
  logic at_end;

  assign at_end = (cnt == cur_period - 1'b1);
  assign next_cnt = at_end ? '0 : cnt + 1'b1;

  // ----------------------------------------------------------------
  // Counter; period is taken only at a boundary to avoid runts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= '0;
      cur_period <= period;
    end else if (advance) begin
      cnt <= next_cnt;
      if (at_end) begin
        cur_period <= period; // R15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      wave <= 1'b0;
    end else if (advance) begin
      wave <= (next_cnt < (cur_period - (cur_period >> 1)));
    end
  end

endmodule : mcg_sqdiv
`default_nettype wire

// ==== hw/mcg_top.sv ====
/*
  Microcontroller clock output generator: configuration register,
  source selection by device state, crystal and RC dividers, standby
  tail with interrupt, and pin drive.
  Assumes dev_state, rc_osc and register strobes are synchronous to clk,
  and that clk runs at twice the crystal frequency.
*/
`timescale 1ns/10ps
`default_nettype none
module mcg_top
  import mcg_pkg::*;
#(
  parameter int TAIL_LIMIT = STANDBY_MAX_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire mcg_state_t dev_state,
  input wire logic rc_osc,
  input wire logic pin_route_clk,
  output logic mcu_clk,
  output logic mcu_clk_oe,
  output logic standby_irq
);

  mcg_cfg_t cfg;
  mcg_src_t cur_src;
  mcg_src_t want_src;
  mcg_state_t prev_state;
  logic rc_q;
  logic rc_edge;
  logic active;
  logic xo_wave;
  logic rc_slow_wave;
  logic next_mcu_clk;
  logic tail_on;
  logic [TAIL_W-1:0] tail_left;
  logic [TIMER_W-1:0] tail_timer;
  logic standby_entry;

  assign rc_edge = rc_osc ^ rc_q;
  assign active = (dev_state != ST_SHUTDOWN) && (dev_state != ST_STANDBY)
    && (dev_state != ST_SLEEP);
  assign tail_on = (tail_left != '0);
  assign standby_entry = (dev_state == ST_STANDBY)
    && (prev_state != ST_STANDBY) && (prev_state != ST_SHUTDOWN);

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (reg_wr && reg_addr == CFG_OFFSET) begin
      cfg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_addr == CFG_OFFSET) ? cfg : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Track the pin in reset too, so no false edge follows release
      rc_q <= rc_osc;
      prev_state <= ST_SHUTDOWN;
    end else begin
      rc_q <= rc_osc;
      prev_state <= dev_state;
    end
  end

  always_comb begin
    case (dev_state)
      ST_SHUTDOWN: want_src = SRC_OFF; // R12
      // Entry cycle counts as tail, else the RC clock would pause
      ST_STANDBY: want_src = (tail_on
        || (standby_entry && cfg.tail_code != 2'h0)) ? SRC_RC : SRC_OFF; // R05
      ST_SLEEP: want_src = SRC_RC; // R09
      default: want_src = SRC_XO; // R01 R10
    endcase
  end

  // Switching only while the output is low on an RC edge leaves no runt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_src <= SRC_OFF;
    end else if (dev_state == ST_SHUTDOWN) begin
      cur_src <= SRC_OFF; // R12
    end else if (want_src != cur_src && rc_edge && !mcu_clk) begin
      cur_src <= want_src; // R11
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  mcg_sqdiv #(.W(DIV_W)) u_xo_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(cfg.enable && cur_src == SRC_XO), // R14
    .advance(1'b1),
    .period(xo_period(cfg.crystal_divide_code)), // R03
    .wave(xo_wave)
  );

  mcg_sqdiv #(.W(DIV_W)) u_rc_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(cfg.enable && cur_src == SRC_RC && cfg.rc_divide_select),
    .advance(rc_edge),
    .period(RC_SLOW_PERIOD), // R04
    .wave(rc_slow_wave)
  );

  always_comb begin
    next_mcu_clk = 1'b0;
    if (cfg.enable) begin // R14
      case (cur_src)
        SRC_XO: next_mcu_clk = xo_wave;
        SRC_RC: next_mcu_clk = cfg.rc_divide_select ? rc_slow_wave : rc_q;
        default: next_mcu_clk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcu_clk <= 1'b0;
      mcu_clk_oe <= 1'b0;
    end else begin
      mcu_clk <= next_mcu_clk;
      mcu_clk_oe <= cfg.enable && pin_route_clk; // R02
    end
  end

  // ----------------------------------------------------------------
  // Standby tail
  // ----------------------------------------------------------------
  // Tail counts output rising edges; the timer is a hard stop so a
  // stalled RC clock cannot hold the transition open forever.
  always_ff @(posedge clk) begin
    if (!rst_n || dev_state != ST_STANDBY) begin
      tail_left <= '0;
    end else if (standby_entry) begin
      tail_left <= tail_cycles(cfg.tail_code); // R06 R13
    end else if (tail_timer >= TIMER_W'(TAIL_LIMIT - 1)) begin
      tail_left <= '0; // R08
    end else if (tail_on && next_mcu_clk && !mcu_clk) begin
      tail_left <= tail_left - 1'b1; // R05
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !tail_on) begin
      tail_timer <= '0;
    end else if (tail_timer < TIMER_W'(TAIL_LIMIT - 1)) begin
      // Saturates one short of the limit, where the tail is cut
      tail_timer <= tail_timer + 1'b1; // R08
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_irq <= 1'b0;
    end else begin
      standby_irq <= standby_entry; // R07
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_shut_held;
    (dev_state == ST_SHUTDOWN) [*2];
  endsequence

  sequence s_switch_moment;
    rc_edge && !mcu_clk;
  endsequence

  cfg_write_a: assert property ( // R14
    reg_wr && reg_addr == CFG_OFFSET |=> cfg == $past(reg_wdata))
    else $error("config write not stored");

  disabled_off_a: assert property ( // R14
    !cfg.enable |=> !mcu_clk)
    else $error("clock running while disabled");

  shutdown_off_a: assert property ( // R12
    s_shut_held |=> !mcu_clk && cur_src == SRC_OFF)
    else $error("clock present in shutdown");

  standby_irq_a: assert property ( // R07
    standby_entry |=> standby_irq ##1 !standby_irq)
    else $error("standby interrupt not one pulse");

  glitch_free_a: assert property ( // R11
    $changed(cur_src) && cur_src != SRC_OFF |-> $past(rc_edge)
      && !$past(mcu_clk))
    else $error("source switched off an RC edge");

  crystal_back_a: assert property ( // R10
    (active && cur_src != SRC_XO) and s_switch_moment |=> cur_src == SRC_XO)
    else $error("crystal not restored in active state");

  sleep_rc_a: assert property ( // R09
    (dev_state == ST_SLEEP) and s_switch_moment |=> cur_src == SRC_RC)
    else $error("sleep did not move to RC");

  crystal_follow_a: assert property ( // R03
    cfg.enable && cur_src == SRC_XO |=> mcu_clk == $past(xo_wave))
    else $error("crystal output not divider wave");

  tail_bound_a: assert property ( // R08
    tail_timer < TIMER_W'(TAIL_LIMIT))
    else $error("standby tail exceeded its limit");

  tail_load_a: assert property ( // R13
    standby_entry |=> tail_left == tail_cycles($past(cfg.tail_code)))
    else $error("tail length wrongly loaded");

endmodule : mcg_top
`default_nettype wire

// ==== verification/mcg_mcu_model.sv ====
/*
  MCU model: watches the clock pin and times each rising edge in clk
  cycles. Assumes the pin is pulled low while it is not driven.
*/
`timescale 1ns/10ps
`default_nettype none
module mcg_mcu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mcu_clk,
  input wire logic mcu_clk_oe,
  output logic meas_v,
  output logic [15:0] meas_per,
  output logic [15:0] rises
);
  logic pin;
  logic pin_q;
  logic [15:0] gap;
  assign pin = mcu_clk_oe & mcu_clk;
  always_ff @(posedge clk) begin
    pin_q <= pin;
    meas_v <= rst_n & pin & ~pin_q;
    if (!rst_n) begin
      gap <= 16'h0001;
      rises <= 16'h0000;
      meas_per <= 16'h0000;
    end else if (pin & ~pin_q) begin
      meas_per <= gap;
      gap <= 16'h0001;
      rises <= rises + 16'h0001;
    end else begin
      gap <= gap + 16'h0001;
    end
  end
endmodule : mcg_mcu_model
`default_nettype wire

// ==== verification/tb_mcu_clock_output_gen.sv ====
/*
  Self-checking bench for the MCU clock generator with an MCU model.
  Assumes one 10 MHz clock; the RC clock is made here, 10 cycles long.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_clock_output_gen
  import mcg_pkg::*;
;
  logic clk = 0, rst_n = 0, reg_wr = 0, rc_osc = 0, pin_route_clk = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  mcg_state_t dev_state = ST_SHUTDOWN;
  logic mcu_clk, mcu_clk_oe, standby_irq, meas_v;
  logic [15:0] meas_per, rises, r0;
  logic [15:0] q[$];
  int fails = 0, tests_run = 0, ncyc = 0;
  // Clock periods per code: clk is twice the crystal rate
  int xo_per[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 72, 96, 128, 192,
                     256, 384};
  // Extra cycles per tail code
  int tail_n[4] = '{0, 64, 256, 512};

  mcg_top #(.TAIL_LIMIT(6000)) mcg_top_i (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .dev_state(dev_state), .rc_osc(rc_osc),
    .pin_route_clk(pin_route_clk), .mcu_clk(mcu_clk),
    .mcu_clk_oe(mcu_clk_oe), .standby_irq(standby_irq));
  mcg_mcu_model mcg_mcu_model_i (.clk(clk), .rst_n(rst_n),
    .mcu_clk(mcu_clk), .mcu_clk_oe(mcu_clk_oe), .meas_v(meas_v),
    .meas_per(meas_per), .rises(rises));

  // ----------------------------------------
  // Clocks, watchdog, result watcher
  // ----------------------------------------
  initial forever #50 clk = ~clk;
  initial forever begin
    // Odd half period, so RC edges meet both crystal phases
    repeat (5) @(posedge clk);
    #1 rc_osc = ~rc_osc;
  end
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    if (ncyc == 60000) begin
      fails++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (meas_v === 1'b1 && q.size() != 0) begin
      chk("period", q.pop_front(), meas_per);
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    cyc(2);
    chk("rdata", e, reg_rdata);
  endtask : rd
  // Checks start with the period in flight; callers wait out any changeover first
  task automatic expect_per(input logic [15:0] e, input int n);
    repeat (n) q.push_back(e);
    while (q.size() != 0) cyc(1);
  endtask : expect_per
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(1));
    cyc(10);
    rst_n = 1;
    rd(8'h06, 8'h00);
    v = 8'($urandom());
    wr(8'h06, v);
    rd(8'h06, v);
    wr(8'($urandom_range(255, 7)), 8'hff);
    rd(reg_addr, 8'h00);
    rd(8'h06, v);
    pin_route_clk = 1;
    dev_state = ST_READY;
    for (int c = 0; c < 16; c++) begin
      wr(8'h06, {3'b100, 4'(c), 1'b0});
      cyc(400);
      expect_per(16'(xo_per[c]), 2);
    end
    while (meas_v !== 1'b1) cyc(1);
    cyc(10);
    q.push_back(16'd384);
    wr(8'h06, 8'h80);
    expect_per(16'd2, 2);
    wr(8'h06, 8'h00);
    r0 = rises;
    cyc(50);
    chk("oe", 1'b0, mcu_clk_oe);
    chk("rises", r0, rises);
    wr(8'h06, 8'h80);
    pin_route_clk = 0;
    cyc(4);
    chk("oe", 1'b0, mcu_clk_oe);
    pin_route_clk = 1;
    cyc(4);
    chk("oe", 1'b1, mcu_clk_oe);
    dev_state = ST_SLEEP;
    cyc(40);
    expect_per(16'd10, 2);
    wr(8'h06, 8'h81);
    cyc(2100);
    expect_per(16'd1280, 1);
    dev_state = ST_READY;
    cyc(700);
    expect_per(16'd2, 2);
    for (int t = 0; t < 4; t++) begin
      wr(8'h06, {1'b1, 2'(t), 5'h00});
      dev_state = ST_SLEEP;
      cyc(40);
      dev_state = ST_STANDBY;
      cyc(1);
      chk("irq", 1'b1, standby_irq);
      cyc(1);
      chk("irq", 1'b0, standby_irq);
      // Model counts a rise one edge late; tail counts from here on
      r0 = rises;
      cyc(10 * tail_n[t] + 100);
      chk("tail", 16'(tail_n[t]), rises - r0);
      chk("stopped", 1'b0, mcu_clk);
    end
    // Longest tail on the slow RC clock must be cut by the limit
    wr(8'h06, 8'he1);
    dev_state = ST_SLEEP;
    cyc(40);
    dev_state = ST_STANDBY;
    cyc(6800);
    r0 = rises;
    cyc(1300);
    chk("timeout", r0, rises);
    chk("stopped", 1'b0, mcu_clk);
    dev_state = ST_READY;
    wr(8'h06, 8'h80);
    cyc(40);
    dev_state = ST_SHUTDOWN;
    cyc(3);
    r0 = rises;
    cyc(100);
    chk("rises", r0, rises);
    chk("clock", 1'b0, mcu_clk);
    print_verdict();
  end
endmodule : tb_mcu_clock_output_gen
`default_nettype wire
